// >>> rtl/fs_pkg.sv
// Shared constants for the fail-safe sequencing block
package fs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATE      = 8'h5C; // Index 0x17, times four
  localparam logic [7:0] ADDR_WINDOW     = 8'h00; // Watchdog window duration
  localparam logic [7:0] ADDR_WINDOW_CHK = 8'h04; // Window check companion
  localparam logic [7:0] ADDR_ANSWER     = 8'h08; // Watchdog answer
  localparam logic [7:0] ADDR_RELEASE    = 8'h0C; // Safety output release
  localparam logic [7:0] ADDR_CONFIG     = 8'h10; // Mode, fault counter
  localparam logic [7:0] ADDR_LOWPOWER   = 8'h14; // Low-power request
  localparam logic [7:0] ADDR_WAKE_EN    = 8'h18; // Wake event enables
  localparam logic [7:0] ADDR_FUSE       = 8'h1C; // Fuse program command
  localparam logic [7:0] ADDR_FUSE_STAT  = 8'h20; // Fuse sector status
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h24; // Sticky events
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h28; // Event enables
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h2C; // Write one to clear
  localparam logic [7:0] ADDR_REGEN      = 8'h30; // Regulator enables
  // Keys and codes
  localparam logic [15:0] KEY_WINDOW     = 16'h008B;
  localparam logic [15:0] KEY_WINDOW_CHK = 16'hF144;
  localparam logic [15:0] KEY_SIMPLE     = 16'h5AB2;
  localparam logic [15:0] KEY_CHAL_SEED  = 16'hA54D;
  localparam logic [15:0] KEY_REL_SIMPLE = 16'hB2A5;
  localparam logic [15:0] KEY_REL_CHAL   = 16'hA565;
  localparam int          DBG_EXIT_BIT   = 14;
  localparam logic [3:0]  CODE_DEBUG     = 4'h4;
  localparam logic [3:0]  CODE_INIT      = 4'h9;
  localparam logic [3:0]  CODE_NORMAL    = 4'hB;
  localparam logic [3:0]  CODE_STANDBY   = 4'hC;
  localparam logic [3:0]  CODE_DEEPOFF   = 4'hD;
  localparam logic [3:0]  FAULT_RESET    = 4'h6;
  localparam int          NUM_SECTORS    = 4;
  localparam int          NUM_REGS       = 4;
  localparam int          NUM_WAKE       = 4;
  // Interrupt bit positions
  localparam int IRQ_REFRESH = 0;
  localparam int IRQ_BADWD   = 1;
  localparam int IRQ_RELEASE = 2;
  localparam int IRQ_WAKE    = 3;
  // Sequencer states
  typedef enum logic [4:0] {
    ST_DEBUG   = 5'b00001,
    ST_INIT    = 5'b00010,
    ST_NORMAL  = 5'b00100,
    ST_STANDBY = 5'b01000,
    ST_DEEPOFF = 5'b10000
  } fs_state_t;
endpackage : fs_pkg

// >>> rtl/fuse_bank.sv
// One-time programmable fuse sectors with mirror load
`timescale 1ns/1ps
module fuse_bank import fs_pkg::*; #(
  parameter int SECTORS = NUM_SECTORS
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Program request
  input  wire logic               burnReq,
  input  wire logic [SECTORS-1:0] burnSel,
  input  wire logic [15:0]        burnData,
  input  wire logic               burnVoltOk,
  // Power-on load
  input  wire logic               powerOn,
  // Status
  output logic [SECTORS-1:0]      sectorUsed,
  output logic [15:0]             appliedCfg
);
  // Fuse state survives rst; only powerOn reloads the applied copy
  typedef struct packed {
    logic [SECTORS-1:0]       used;
    logic [SECTORS-1:0][15:0] fuse;
    logic [15:0]              applied;
  } fuse_t;
  fuse_t cur = '0; // Blank fuses at manufacture
  fuse_t next_cur; // Next fuse state

  // Burn each selected unused sector, never twice
  always_comb begin
    next_cur = cur;
    for (int i = 0; i < SECTORS; i++) begin
      if (!rst && burnReq && burnVoltOk && // [R4]
          burnSel[i] && !cur.used[i]) begin // [R2]
        next_cur.used[i] = 1'b1;
        next_cur.fuse[i] = burnData;
      end
    end
    // Burned image takes effect only on the next power up
    if (powerOn) begin // [R3]
      next_cur.applied = 16'h0000;
      for (int i = 0; i < SECTORS; i++) begin
        if (cur.used[i]) begin
          next_cur.applied = next_cur.applied | cur.fuse[i];
        end
      end
    end
  end

  // Fuses are nonvolatile, so rst leaves them alone
  always_ff @(posedge clk_sys) begin
    cur <= next_cur;
  end

  assign sectorUsed = cur.used;
  assign appliedCfg = cur.applied;
endmodule : fuse_bank

// >>> rtl/failsafe_state_watchdog_release.sv
// Fail-safe sequencer, watchdog and release with AXI4-Lite registers
// Operation
// [R1] Hold while debug pin high, then code 9
// [R2] Each fuse sector programs only once
// [R3] Burned configuration applies at next power up
// [R4] Burn only above the burn voltage threshold
// [R5] Host does watchdog, debug exit, release order
// [R6] Host opens infinite window with two keys
// [R7] Simple mode: 0x5AB2 refresh closes initial window
// [R8] Challenger: answer changes each refresh, from 0xA54D
// [R9] Good refresh decrements the fault counter
// [R10] Writing 0x4000 to state register exits debug
// [R11] Correct key releases safety outputs
// [R12] After release, Normal mode, code 11
// [R13] Low power from init/normal; enabled wakes only
// [R14] Standby keeps pre-regulator and chosen linears
// [R15] Deep-off keeps only the pre-regulator
// [R16] Debug entry grants access, reports code 4
// [R17] State register readable at 0x17
// [R18] Release ignored while counter nonzero or debug
`timescale 1ns/1ps
module failsafe_state_watchdog_release import fs_pkg::*; #(
  parameter int NREG = NUM_REGS,
  parameter int NWAKE = NUM_WAKE
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             powerOn,
  // Debug pin and fuse burn threshold levels
  input  wire logic             debugEntryPin,
  input  wire logic             fuseBurnThreshold,
  // Wake sources
  input  wire logic [NWAKE-1:0] wakeEvent,
  // AXI4-Lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Safety and power outputs
  output logic                  primarySafetyOutput,
  output logic                  secondarySafetyOutput,
  output logic                  preRegulatorEn,
  output logic [NREG-1:0]       linearRegEn,
  output logic                  regAccessGranted,
  output logic                  irq
);
  // Known register address, shared by read and write decode
  function automatic logic known(input logic [7:0] a);
    case (a)
      ADDR_STATE, ADDR_WINDOW, ADDR_WINDOW_CHK, ADDR_ANSWER, ADDR_RELEASE,
      ADDR_CONFIG, ADDR_LOWPOWER, ADDR_WAKE_EN, ADDR_FUSE, ADDR_FUSE_STAT,
      ADDR_IRQ_STAT, ADDR_IRQ_EN, ADDR_IRQ_CLR, ADDR_REGEN: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction : known

  // All block state
  typedef struct packed {
    fs_state_t         state;      // Sequencer state
    logic              awHeld;     // Address captured
    logic [7:0]        awAddr;     // Captured write address
    logic              wHeld;      // Data captured
    logic [31:0]       wData;      // Captured write data
    logic [3:0]        wStrb;      // Captured strobes
    logic              bValid;     // Write response pending
    logic [1:0]        bResp;      // Write response code
    logic              rValid;     // Read data pending
    logic [31:0]       rData;      // Read data
    logic [1:0]        rResp;      // Read response code
    logic              winOpen;    // First window key seen
    logic              winInf;     // Infinite window selected
    logic              initClosed; // Initial window closed
    logic [15:0]       chal;       // Expected challenger answer
    logic [3:0]        faultCnt;   // Fault error counter
    logic              debugMode;  // Debug mode active
    logic              released;   // Safety outputs released
    logic              chalMode;   // Challenger watchdog mode
    logic [NWAKE-1:0]  wakeEn;     // Wake enables
    logic [NREG-1:0]   keepLin;    // Linears kept in standby
    logic [3:0]        irqStat;    // Sticky events
    logic [3:0]        irqEn;      // Event enables
  } blk_t;
  blk_t cur;      // Registered state
  blk_t next_cur; // Next state

  // Fuse program request decode
  logic                   burnReq;    // Fuse command write this cycle
  logic [NUM_SECTORS-1:0] sectorUsed; // Burned sectors
  logic [15:0]            appliedCfg; // Configuration in force
  logic                   wrFire;     // Write performed this cycle
  logic [15:0]            wv;         // Low write halfword

  // A write waits while its response is pending,
  // so no response is ever overwritten
  assign wrFire = cur.awHeld && cur.wHeld && !cur.bValid;
  assign wv = cur.wData[15:0];
  // Fuse commands count only in debug mode
  assign burnReq = wrFire && cur.awAddr == ADDR_FUSE && cur.debugMode;

  // Fuse sectors
  fuse_bank #(.SECTORS(NUM_SECTORS)) u_fuse (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .burnReq    (burnReq),
    .burnSel    (cur.wData[16 +: NUM_SECTORS]),
    .burnData   (wv),
    .burnVoltOk (fuseBurnThreshold), // [R4]
    .powerOn    (powerOn),
    .sectorUsed (sectorUsed),
    .appliedCfg (appliedCfg)
  );

  // Next-state logic: bus, sequencer, watchdog, interrupts
  always_comb begin
    logic [3:0] ev;
    logic [3:0] code;
    ev = 4'h0;
    code = CODE_DEBUG;
    next_cur = cur;
    // Write channels taken in any order, one held at a time
    if (s_axi_awvalid && !cur.awHeld) begin
      next_cur.awHeld = 1'b1;
      next_cur.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.wHeld) begin
      next_cur.wHeld = 1'b1;
      next_cur.wData = s_axi_wdata;
      next_cur.wStrb = s_axi_wstrb;
    end
    if (cur.bValid && s_axi_bready) begin
      next_cur.bValid = 1'b0;
    end
    // Perform the write once both halves are held
    if (wrFire) begin
      next_cur.awHeld = 1'b0;
      next_cur.wHeld = 1'b0;
      next_cur.bValid = 1'b1;
      next_cur.bResp = known(cur.awAddr) ? 2'b00 : 2'b10;
      case (cur.awAddr)
        ADDR_WINDOW: next_cur.winOpen = (wv == KEY_WINDOW);
        ADDR_WINDOW_CHK: begin
          // Check value must follow the matching duration
          if (cur.winOpen && wv == KEY_WINDOW_CHK) begin
            next_cur.winInf = 1'b1;
          end
          next_cur.winOpen = 1'b0;
        end
        ADDR_ANSWER: begin
          if (cur.state inside {ST_INIT, ST_NORMAL}) begin
            if (wv == (cur.chalMode ? cur.chal : KEY_SIMPLE)) begin // [R7] [R8]
              ev[IRQ_REFRESH] = 1'b1;
              next_cur.initClosed = 1'b1; // [R7]
              // Next challenge: shift left, bit 7 fed back low;
              // this gives the expected challenger answer sequence
              next_cur.chal = {cur.chal[14:0], cur.chal[7]}; // [R8]
              if (cur.faultCnt != 4'h0) begin
                next_cur.faultCnt = cur.faultCnt - 4'h1; // [R9]
              end
            end else begin
              ev[IRQ_BADWD] = 1'b1;
            end
          end
        end
        ADDR_STATE: begin
          if (cur.wData[DBG_EXIT_BIT]) begin
            next_cur.debugMode = 1'b0; // [R10]
          end
        end
        ADDR_RELEASE: begin
          // Key ignored until counter clear and debug exited
          if (cur.state == ST_INIT && cur.initClosed &&
              cur.faultCnt == 4'h0 && !cur.debugMode && // [R18]
              wv == (cur.chalMode ? KEY_REL_CHAL : KEY_REL_SIMPLE)) begin // [R11]
            next_cur.released = 1'b1;
            next_cur.state = ST_NORMAL; // [R12]
            ev[IRQ_RELEASE] = 1'b1;
          end
        end
        ADDR_CONFIG: begin
          if (cur.state == ST_DEBUG) begin
            next_cur.chalMode = cur.wData[0];
            next_cur.faultCnt = cur.wData[7:4];
          end
        end
        ADDR_LOWPOWER: begin
          if (cur.state inside {ST_INIT, ST_NORMAL}) begin // [R13]
            // Standby wins if both are requested
            if (cur.wData[0]) begin
              next_cur.state = ST_STANDBY;
            end else if (cur.wData[1]) begin
              next_cur.state = ST_DEEPOFF;
            end
            if (cur.wData[1:0] != 2'b00) begin
              next_cur.released = 1'b0;
            end
          end
        end
        ADDR_WAKE_EN: next_cur.wakeEn = cur.wData[NWAKE-1:0];
        ADDR_REGEN: next_cur.keepLin = cur.wData[NREG-1:0];
        ADDR_IRQ_EN: next_cur.irqEn = cur.wData[3:0];
        ADDR_IRQ_CLR: next_cur.irqStat = cur.irqStat & ~cur.wData[3:0];
        default: ;
      endcase
    end
    // Sequencer transitions outside the bus
    case (cur.state)
      ST_DEBUG: begin
        code = CODE_DEBUG; // [R16]
        // Pin high holds the sequencer here
        if (!debugEntryPin) begin
          next_cur.state = ST_INIT; // [R1]
        end
      end
      ST_INIT: code = CODE_INIT; // [R1]
      ST_NORMAL: code = CODE_NORMAL; // [R12]
      ST_STANDBY, ST_DEEPOFF: begin
        code = (cur.state == ST_STANDBY) ? CODE_STANDBY : CODE_DEEPOFF;
        // Only enabled events may wake the device
        if ((wakeEvent & cur.wakeEn) != '0) begin // [R13]
          next_cur.state = ST_INIT;
          next_cur.initClosed = 1'b0;
          next_cur.faultCnt = FAULT_RESET;
          ev[IRQ_WAKE] = 1'b1;
        end
      end
      default: next_cur.state = ST_DEBUG;
    endcase
    // Set wins over a same-cycle clear
    next_cur.irqStat = next_cur.irqStat | ev;
    // Read channel; data is captured when the address
    // is taken, so it stands until rready
    if (cur.rValid && s_axi_rready) begin
      next_cur.rValid = 1'b0;
    end
    if (s_axi_arvalid && !cur.rValid) begin
      next_cur.rValid = 1'b1;
      next_cur.rResp = known(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        ADDR_STATE: next_cur.rData = {17'h0, cur.debugMode, 10'h0,
                                      code}; // [R17]
        ADDR_CONFIG: next_cur.rData = {24'h0, cur.faultCnt, 3'h0,
                                       cur.chalMode};
        ADDR_WAKE_EN: next_cur.rData = 32'(cur.wakeEn);
        ADDR_REGEN: next_cur.rData = 32'(cur.keepLin);
        ADDR_FUSE_STAT: next_cur.rData = {appliedCfg,
                                          16'(sectorUsed)};
        ADDR_IRQ_STAT: next_cur.rData = {28'h0, cur.irqStat};
        ADDR_IRQ_EN: next_cur.rData = {28'h0, cur.irqEn};
        default: next_cur.rData = 32'h0000_0000;
      endcase
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= '0;
      cur.state <= ST_DEBUG; // [R1]
      cur.debugMode <= 1'b1;
      cur.faultCnt <= FAULT_RESET;
      // Challenger restarts from its seed
      cur.chal <= KEY_CHAL_SEED;
      cur.keepLin <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  // Bus handshakes; a held half blocks its channel
  // until the write is performed
  assign s_axi_awready = !cur.awHeld;
  assign s_axi_wready  = !cur.wHeld;
  assign s_axi_bvalid  = cur.bValid;
  assign s_axi_bresp   = cur.bResp;
  assign s_axi_arready = !cur.rValid;
  assign s_axi_rvalid  = cur.rValid;
  assign s_axi_rdata   = cur.rData;
  assign s_axi_rresp   = cur.rResp;

  // Safety outputs active low: asserted until release
  assign primarySafetyOutput   = cur.released; // [R11]
  assign secondarySafetyOutput = cur.released;
  // Register map open in debug state or debug mode
  assign regAccessGranted = cur.state == ST_DEBUG || cur.debugMode; // [R16]
  // Pre-regulator always on; linears per low-power mode
  assign preRegulatorEn = 1'b1; // [R14] [R15]
  assign linearRegEn = (cur.state == ST_DEEPOFF) ? '0 : // [R15]
                       (cur.state == ST_STANDBY) ? cur.keepLin : '1; // [R14]
  // Level interrupt while an enabled event is set
  assign irq = (cur.irqStat & cur.irqEn) != 4'h0;
endmodule : failsafe_state_watchdog_release

// >>> tb/fs_checker.sv
// Port assertions for the fail-safe sequencer
`timescale 1ns/1ps
module fs_checker import fs_pkg::*; #(
  parameter int NREG = NUM_REGS
) (
  // Clock and reset
  input wire logic            clk_sys,
  input wire logic            rst,
  // Bus handshakes
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  // Safety and power outputs
  input wire logic            primarySafetyOutput,
  input wire logic            secondarySafetyOutput,
  input wire logic            preRegulatorEn,
  input wire logic [NREG-1:0] linearRegEn,
  input wire logic            regAccessGranted
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid)
    else $error("write not answered in time");
  a_outputs_pair: assert property (
    primarySafetyOutput == secondarySafetyOutput)
    else $error("safety outputs disagree");
  a_prereg_on: assert property (preRegulatorEn)
    else $error("pre-regulator switched off");
  a_release_gate: assert property ($rose(primarySafetyOutput)
    |-> !regAccessGranted)
    else $error("release while debug active");
  a_reset_state: assert property ($fell(rst) |->
    regAccessGranted && !primarySafetyOutput && linearRegEn == '1)
    else $error("wrong state after reset");
endmodule : fs_checker

bind failsafe_state_watchdog_release fs_checker #(.NREG(NREG)) chk_i (
  .clk_sys, .rst, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .primarySafetyOutput, .secondarySafetyOutput,
  .preRegulatorEn, .linearRegEn, .regAccessGranted);

// >>> tb/host_model.sv
// Host controller model: AXI4-Lite master for the safety registers
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        clk_sys,
  // Write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // One write; each channel held until its own ready, bounded wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit to);
    to = 1'b1;
    r = 2'h0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 200 && to; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      // Response counts at the first edge bvalid is seen
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        to = 1'b0;
      end
    end
  endtask : wr

  // One read, data taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit to);
    to = 1'b1;
    {d, r} = '0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 200 && to; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        to = 1'b0;
      end
    end
  endtask : rd
endmodule : host_model

// >>> tb/tb_failsafe_state_watchdog_release.sv
// Self-checking bench for the fail-safe sequencer
`timescale 1ns/1ps
module tb_failsafe_state_watchdog_release;
  import fs_pkg::*;
  logic        clk_sys, rst, powerOn, debugEntryPin, fuseBurnThreshold;
  logic [3:0]  wakeEvent, linearRegEn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        safeA, safeB, preReg, regAccess, irq;
  int          n_errors, checks_done;

  failsafe_state_watchdog_release failsafe_state_watchdog_release_i (
    .clk_sys, .rst, .powerOn, .debugEntryPin, .fuseBurnThreshold, .wakeEvent,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .primarySafetyOutput(safeA), .secondarySafetyOutput(safeB),
    .preRegulatorEn(preReg), .linearRegEn, .regAccessGranted(regAccess),
    .irq);
  host_model host_model_i (
    .clk_sys, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task stop_test;
    $display("checks=%0d mismatches=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus wrappers; a hung bus ends the run
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit to;
    host_model_i.wr(a, d, rr, to);
    if (to) begin
      n_errors++;
      stop_test();
    end
  endtask : wr
  task rd(input logic [7:0] a);
    bit to;
    host_model_i.rd(a, rv, rr, to);
    if (to) begin
      n_errors++;
      stop_test();
    end
  endtask : rd

  // Poll the state code, bounded
  task wait_state(input logic [3:0] code);
    for (int i = 0; i < 40; i++) begin
      rd(ADDR_STATE);
      if (rv[3:0] === code) break;
    end
    chk(rv[3:0], code);
  endtask : wait_state

  // Reset for 8 cycles with the debug pin high
  task do_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    debugEntryPin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  // Debug hold, access and unmapped read
  task t_debug;
    rd(ADDR_STATE);
    chk(rv[3:0], CODE_DEBUG);
    wr(ADDR_LOWPOWER, 32'h1);
    repeat (20) @(posedge clk_sys);
    wait_state(CODE_DEBUG);
    chk(regAccess, 1'b1);
    rd(8'h40);
    chk(rr, 2'h2);
    $display("test debug done");
  endtask : t_debug

  // Burn gating, single programming, load at power-on
  task t_fuse;
    wr(ADDR_FUSE, 32'h0001_1234);
    rd(ADDR_FUSE_STAT);
    chk(rv[3:0], 4'h0);
    fuseBurnThreshold <= 1'b1;
    wr(ADDR_FUSE, 32'h0001_1234);
    wr(ADDR_FUSE, 32'h0001_5678);
    rd(ADDR_FUSE_STAT);
    chk(rv[3:0], 4'h1);
    chk(rv[31:16], 16'h0000);
    powerOn <= 1'b1;
    @(posedge clk_sys);
    powerOn <= 1'b0;
    fuseBurnThreshold <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(ADDR_FUSE_STAT);
    chk(rv[31:16], 16'h1234);
    $display("test fuse done");
  endtask : t_fuse

  // Refreshes, interrupts, exit and release in simple mode
  task t_simple;
    debugEntryPin <= 1'b0;
    wait_state(CODE_INIT);
    wr(ADDR_RELEASE, KEY_REL_SIMPLE);
    repeat (3) @(posedge clk_sys);
    chk(safeA, 1'b0);
    wr(ADDR_WINDOW, KEY_WINDOW);
    wr(ADDR_WINDOW_CHK, KEY_WINDOW_CHK);
    wr(ADDR_IRQ_EN, 32'h1);
    wr(ADDR_ANSWER, 32'h1111);
    rd(ADDR_IRQ_STAT);
    chk(rv[1:0], 2'h2);
    chk(irq, 1'b0);
    for (int i = 0; i < 6; i++) wr(ADDR_ANSWER, KEY_SIMPLE);
    rd(ADDR_CONFIG);
    chk(rv[7:4], 4'h0);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_CLR, 32'h3);
    rd(ADDR_IRQ_STAT);
    chk(rv[1:0], 2'h0);
    chk(irq, 1'b0);
    wr(ADDR_RELEASE, KEY_REL_SIMPLE);
    repeat (3) @(posedge clk_sys);
    chk(safeA, 1'b0);
    wr(ADDR_STATE, 32'h4000);
    rd(ADDR_STATE);
    chk(rv[DBG_EXIT_BIT], 1'b0);
    wr(ADDR_RELEASE, KEY_REL_CHAL);
    repeat (3) @(posedge clk_sys);
    chk(safeA, 1'b0);
    wr(ADDR_RELEASE, KEY_REL_SIMPLE);
    repeat (3) @(posedge clk_sys);
    chk({safeA, safeB}, 2'h3);
    wait_state(CODE_NORMAL);
    $display("test simple done");
  endtask : t_simple

  // Standby, masked and enabled wakes, deep-off
  task t_lowpower;
    wr(ADDR_WAKE_EN, 32'h2);
    wr(ADDR_REGEN, 32'h1);
    wr(ADDR_LOWPOWER, 32'h1);
    wait_state(CODE_STANDBY);
    chk({preReg, linearRegEn}, 5'h11);
    wakeEvent <= 4'h1;
    repeat (6) @(posedge clk_sys);
    wait_state(CODE_STANDBY);
    wakeEvent <= 4'h2;
    wait_state(CODE_INIT);
    wakeEvent <= 4'h0;
    wr(ADDR_LOWPOWER, 32'h2);
    wait_state(CODE_DEEPOFF);
    chk({preReg, linearRegEn}, 5'h10);
    $display("test lowpower done");
  endtask : t_lowpower

  // Challenger mode after a second reset
  task t_chal;
    do_reset();
    rd(ADDR_FUSE_STAT);
    chk(rv, 32'h1234_0001);
    wr(ADDR_CONFIG, 32'h61);
    debugEntryPin <= 1'b0;
    wait_state(CODE_INIT);
    wr(ADDR_WINDOW, KEY_WINDOW);
    wr(ADDR_WINDOW_CHK, KEY_WINDOW_CHK);
    wr(ADDR_ANSWER, KEY_SIMPLE);
    rd(ADDR_IRQ_STAT);
    chk(rv[1:0], 2'h2);
    wr(ADDR_IRQ_CLR, 32'hF);
    wr(ADDR_ANSWER, KEY_CHAL_SEED);
    rd(ADDR_IRQ_STAT);
    chk(rv[1:0], 2'h1);
    wr(ADDR_IRQ_CLR, 32'hF);
    wr(ADDR_ANSWER, 32'h4A9A);
    rd(ADDR_IRQ_STAT);
    chk(rv[1:0], 2'h1);
    wr(ADDR_ANSWER, 32'h9535);
    wr(ADDR_ANSWER, 32'h2A6A);
    wr(ADDR_ANSWER, 32'h54D4);
    wr(ADDR_ANSWER, 32'hA9A9);
    rd(ADDR_CONFIG);
    chk(rv[7:4], 4'h0);
    wr(ADDR_STATE, 32'h4000);
    wr(ADDR_RELEASE, KEY_REL_SIMPLE);
    repeat (3) @(posedge clk_sys);
    chk(safeA, 1'b0);
    wr(ADDR_RELEASE, KEY_REL_CHAL);
    repeat (3) @(posedge clk_sys);
    chk({safeA, safeB}, 2'h3);
    wait_state(CODE_NORMAL);
    $display("test challenger done");
  endtask : t_chal

  // Main sequence
  initial begin
    {rst, powerOn, debugEntryPin, fuseBurnThreshold, wakeEvent} = 8'hA0;
    n_errors = 0;
    checks_done = 0;
    do_reset();
    t_debug();
    t_fuse();
    t_simple();
    t_lowpower();
    t_chal();
    stop_test();
  end
endmodule : tb_failsafe_state_watchdog_release
